/* common/panel_seq_params.svh */
// Timing and width constants for the panel power and backlight sequencer
`ifndef PANEL_SEQ_PARAMS_SVH
`define PANEL_SEQ_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and millisecond base
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   4
`define MS_NS           1000000
`define MS_CYCLES_DEF   (`MS_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Sequence gaps in milliseconds
// ----------------------------------------------------------------------
`define T2_MIN_MS       16'h001E
`define T2_MAX_MS       16'h005A
`define T3_MIN_MS       16'h00C8
`define T5_MIN_MS       16'h000A
`define T6_MIN_MS       16'h000A
`define T7_MIN_MS       16'h0000
`define T8_MIN_MS       16'h000A
`define T10_MIN_MS      16'h00C8
`define T11_MAX_MS      16'h0032
`define OFF_MS_DEF      16'h01F4
`define SUP_TIMEOUT_MS  16'h0014
`define BLG_TIMEOUT_MS  16'h001E

// ----------------------------------------------------------------------
// Widths and dimming generator
// ----------------------------------------------------------------------
`define WAIT_W          16
`define STATE_W         4
`define DUTY_W          8
`define PWM_TICK_CYCLES 50
`define WAIT_MAX        16'hFFFF

`endif

/* common/panel_seq_pkg.sv */
// Types shared by the panel power and backlight sequencer
`include "panel_seq_params.svh"

package panel_seq_pkg;

  // Sequence states, Gray coded along the power-up and power-down path
  typedef enum logic [`STATE_W-1:0] {
    S_IDLE     = 4'h0,
    S_SUP_WAIT = 4'h1,
    S_SIG_WAIT = 4'h3,
    S_BLP_WAIT = 4'h2,
    S_BLG_WAIT = 4'h6,
    S_PWM_WAIT = 4'h7,
    S_EN_WAIT  = 4'h5,
    S_ON       = 4'h4,
    S_EN_OFF   = 4'hC,
    S_PWM_OFF  = 4'hD,
    S_BLP_OFF  = 4'hF,
    S_SIG_HOLD = 4'hE,
    S_SUP_OFF  = 4'hA,
    S_OFF_WAIT = 4'hB
  } seq_state_t;

  // Pins driven into the display module
  typedef struct packed {
    logic supplyEn;     // module_supply_input switch
    logic signalValid;  // video interface driven valid
    logic blPowerEn;    // backlight driver supply switch
    logic blDimming;    // backlight_dimming_input PWM
    logic blEnable;     // backlight_enable_input
  } panel_pins_t;

endpackage : panel_seq_pkg

/* dv/panel_module_model.sv */
// Behavioural display module side: supply monitors and backlight driver
module panel_module_model
  import panel_seq_pkg::*;
(
  // Clock
  input  wire logic        mclk,
  // Pins from the sequencer
  input  panel_pins_t      panelPins,
  // Scenario knobs
  input  wire logic        supOk,
  input  wire logic        supDrop,
  input  wire logic [15:0] supDelay,
  input  wire logic [15:0] blDelay,
  // Supply monitors and observed state
  output logic             supplyGoodPin = 1'b0,
  output logic             blPowerGoodPin = 1'b0,
  output logic             lit = 1'b0,
  output logic [15:0]      offDrive = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] supCnt_r = 16'h0000;
  logic [15:0] blCnt_r  = 16'h0000;

  // ----------------------------------------------------------------------
  // Supply ramps, driver and off-state watch
  // ----------------------------------------------------------------------
  // Good signals rise a set delay after their switch, drop with it
  always @(posedge mclk) begin
    supCnt_r <= panelPins.supplyEn ? supCnt_r + 16'h0001 : 16'h0000;
    blCnt_r <= panelPins.blPowerEn ? blCnt_r + 16'h0001 : 16'h0000;
    supplyGoodPin <= panelPins.supplyEn && supOk && !supDrop && (supCnt_r >= supDelay);
    blPowerGoodPin <= panelPins.blPowerEn && (blCnt_r >= blDelay);
    lit <= blPowerGoodPin && panelPins.blEnable && panelPins.blDimming;
    if (!panelPins.supplyEn && panelPins[3:0] != 4'h0) begin
      offDrive <= offDrive + 16'h0001;
    end
  end
endmodule : panel_module_model

/* dv/tb_panel_power_backlight_sequencer.sv */
// Self-checking bench for the panel power and backlight sequencer
module tb_panel_power_backlight_sequencer
  import panel_seq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] %0t mismatch got %0h expected %0h", $time, (got), (exp)); end end

  localparam int MS  = 10;
  localparam int OFF = 3;
  localparam int SEN = 8, SIG = 7, BLP = 6, DIM = 5, BEN = 4, SGD = 3, BGD = 2, PON = 1, FLT = 0;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        mclk     = 1'b0;
  logic        rst_n    = 1'b0;
  logic        powerReq = 1'b0;
  logic [7:0]  dimDuty  = 8'hFF;
  logic        supOk    = 1'b1;
  logic        supDrop  = 1'b0;
  logic [15:0] supDelay = 16'h0028;
  logic [15:0] blDelay  = 16'h0019;
  panel_pins_t panelPins;
  logic        panelOn, seqFault, supplyGoodPin, blPowerGoodPin, lit;
  logic [15:0] offDrive;
  logic [8:0]  sig;
  logic [8:0]  sigQ = 9'h000;
  int          tRise[9];
  int          tFall[9];
  int          cyc = 0;
  int          fail_count = 0;
  int          comparisons = 0;

  assign sig = {panelPins, supplyGoodPin, blPowerGoodPin, panelOn, seqFault};

  // Free-running clock
  initial begin
    forever #2 mclk = ~mclk;
  end

  panel_power_backlight_sequencer #(.MS_CYCLES(MS), .OFF_MS(16'h0003))
    u_panel_power_backlight_sequencer (.mclk(mclk), .rst_n(rst_n), .powerReq(powerReq),
      .dimDuty(dimDuty), .supplyGoodPin(supplyGoodPin), .blPowerGoodPin(blPowerGoodPin),
      .panelPins(panelPins), .panelOn(panelOn), .seqFault(seqFault));

  panel_module_model u_panel_module_model (.mclk(mclk), .panelPins(panelPins),
    .supOk(supOk), .supDrop(supDrop), .supDelay(supDelay), .blDelay(blDelay),
    .supplyGoodPin(supplyGoodPin), .blPowerGoodPin(blPowerGoodPin), .lit(lit),
    .offDrive(offDrive));

  // Edge time stamps of every observed line, settled before the next negedge
  always @(posedge mclk) begin
    #1;
    cyc++;
    for (int i = 0; i < 9; i++) begin
      if (sig[i] === 1'b1 && sigQ[i] !== 1'b1) tRise[i] = cyc;
      if (sig[i] === 1'b0 && sigQ[i] === 1'b1) tFall[i] = cyc;
    end
    sigQ = sig;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // Bounded wait for one observed line to reach a level
  task automatic waitPin(input int idx, input logic val, input int bound);
    int n;
    n = 0;
    while (sig[idx] !== val && n < bound) begin
      @(negedge mclk);
      n++;
    end
    if (sig[idx] !== val) begin
      fail_count++;
      $display("[FAIL] %0t wait on line %0d timed out", $time, idx);
      summarize();
    end
  endtask : waitPin

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic testReset();
    `CHECK({sig[8:4], sig[1:0]}, 7'h00)
    $display("test reset done");
  endtask : testReset

  task automatic testPowerUp();
    @(posedge mclk);
    powerReq <= 1'b1;
    waitPin(PON, 1'b1, 400 * MS);
    repeat (2) @(negedge mclk);
    `CHECK(tRise[SIG] - tRise[SGD] >= 30 * MS, 1'b1)
    `CHECK(tRise[SIG] - tRise[SGD] <= 90 * MS, 1'b1)
    `CHECK(tRise[BLP] - tRise[SIG] >= 200 * MS, 1'b1)
    `CHECK(tRise[DIM] - tRise[BGD] >= 10 * MS, 1'b1)
    `CHECK(tRise[BEN] - tRise[DIM] >= 10 * MS, 1'b1)
    `CHECK({sig[BEN], lit, sig[FLT]}, 3'b110)
    $display("test power up done");
  endtask : testPowerUp

  // Full power-down, restart after off time, then abort early
  task automatic testPowerDown();
    int sigUp;
    @(posedge mclk);
    powerReq <= 1'b0;
    waitPin(SEN, 1'b0, 400 * MS);
    `CHECK(tFall[DIM] >= tFall[BEN], 1'b1)
    `CHECK(tFall[BLP] > tFall[BEN], 1'b1)
    `CHECK(tFall[BLP] - tFall[DIM] >= 10 * MS, 1'b1)
    `CHECK(tFall[SIG] - tFall[BLP] >= 200 * MS, 1'b1)
    `CHECK(tFall[SEN] - tFall[SIG] <= 50 * MS, 1'b1)
    `CHECK(tFall[SEN] >= tFall[SIG], 1'b1)
    @(posedge mclk);
    powerReq <= 1'b1;
    waitPin(SEN, 1'b1, 20 * MS);
    `CHECK(tRise[SEN] - tFall[SEN] >= OFF * MS, 1'b1)
    sigUp = tRise[SIG];
    repeat (5 * MS) @(posedge mclk);
    powerReq <= 1'b0;
    waitPin(SEN, 1'b0, 40 * MS);
    `CHECK({tRise[SIG] == sigUp, sig[7:4], sig[FLT]}, 6'h20)
    $display("test power down done");
  endtask : testPowerDown

  task automatic testSupplyTimeout();
    @(posedge mclk);
    supOk <= 1'b0;
    powerReq <= 1'b1;
    waitPin(SEN, 1'b1, 20 * MS);
    waitPin(SEN, 1'b0, 40 * MS);
    @(posedge mclk);
    powerReq <= 1'b0;
    repeat (2) @(negedge mclk);
    `CHECK({sig[7:4], sig[FLT]}, 5'h01)
    $display("test supply timeout done");
  endtask : testSupplyTimeout

  task automatic testSupplyLoss();
    @(posedge mclk);
    supOk <= 1'b1;
    powerReq <= 1'b1;
    waitPin(PON, 1'b1, 400 * MS);
    `CHECK(sig[FLT], 1'b0)
    @(posedge mclk);
    dimDuty <= 8'h00;
    repeat (3) @(negedge mclk);
    `CHECK({sig[DIM], lit}, 2'b00)
    @(posedge mclk);
    dimDuty <= 8'hFF;
    repeat (3) @(negedge mclk);
    `CHECK({sig[DIM], lit}, 2'b11)
    @(posedge mclk);
    supDrop <= 1'b1;
    waitPin(SIG, 1'b0, 6);
    repeat (2) @(negedge mclk);
    `CHECK({sig[8:4], sig[FLT]}, 6'h01)
    @(posedge mclk);
    powerReq <= 1'b0;
    supDrop <= 1'b0;
    repeat (5 * MS) @(negedge mclk);
    `CHECK(offDrive, 16'h0000)
    $display("test supply loss done");
  endtask : testSupplyLoss

  // Backlight supply never good: down path without starting the PWM
  task automatic testBacklightTimeout();
    int dimUp;
    dimUp = tRise[DIM];
    @(posedge mclk);
    blDelay <= 16'hFFFF;
    powerReq <= 1'b1;
    waitPin(BLP, 1'b1, 400 * MS);
    waitPin(BLP, 1'b0, 40 * MS);
    `CHECK(tFall[BLP] - tRise[BLP] >= 30 * MS, 1'b1)
    `CHECK(tFall[BLP] - tRise[BLP] <= 31 * MS, 1'b1)
    waitPin(SEN, 1'b0, 250 * MS);
    `CHECK({tRise[DIM] == dimUp, sig[7:4], sig[FLT]}, 6'h21)
    @(posedge mclk);
    powerReq <= 1'b0;
    blDelay <= 16'h0019;
    $display("test backlight timeout done");
  endtask : testBacklightTimeout

  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    testReset();
    testPowerUp();
    testPowerDown();
    testSupplyTimeout();
    testSupplyLoss();
    testBacklightTimeout();
    summarize();
  end
endmodule : tb_panel_power_backlight_sequencer

/* src/ms_tick_gen.sv */
// Clock divider giving a one-cycle enable pulse every DIV cycles
module ms_tick_gen #(
  parameter int unsigned DIV = 2
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Restart the period
  input  wire logic clear,
  // Enable pulse
  output logic      tick
);

  logic [31:0] count_r;

  // ----------------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n || clear) begin
      count_r <= 32'h0;
      tick    <= 1'b0;
    end else if (count_r == 32'(DIV - 1)) begin
      count_r <= 32'h0;
      tick    <= 1'b1;
    end else begin
      count_r <= count_r + 32'h1;
      tick    <= 1'b0;
    end
  end

endmodule : ms_tick_gen

/* src/panel_power_backlight_sequencer.sv */
// Host-side power and backlight sequencer for a display module
// Contract
// - Interface signals go valid between 30 ms and 90 ms after module supply is good.
// - Backlight power switches on no sooner than 200 ms after signals go valid.
// - Dimming PWM starts no sooner than 10 ms after backlight power is good.
// - Backlight enable rises no sooner than 10 ms after the dimming PWM starts.
// - On power-down the backlight enable falls first, the PWM stops with it or later.
// - Backlight power is removed no sooner than 10 ms after the PWM stops.
// - Signals stay valid at least 200 ms after the backlight is off, then are disabled.
// - Module supply is removed within 0 to 50 ms after the signals are disabled.
// - While module supply is off every output to the module is low.
// - While module supply is on every module input is actively driven.
// - The dimming PWM output feeds the backlight driver brightness input.
// - The backlight enable is a separate logic level that switches the driver.
`include "panel_seq_params.svh"

module panel_power_backlight_sequencer
  import panel_seq_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `MS_CYCLES_DEF,
  parameter logic [`WAIT_W-1:0] OFF_MS = `OFF_MS_DEF
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // Host control
  input  wire logic               powerReq,
  input  wire logic [`DUTY_W-1:0] dimDuty,
  // Supply monitors from the board
  input  wire logic               supplyGoodPin,
  input  wire logic               blPowerGoodPin,
  // Pins to the display module
  output panel_pins_t             panelPins,
  // Status
  output logic                    panelOn,
  output logic                    seqFault
);

  seq_state_t          state_r, state_nxt;
  logic [1:0]          supSync_r, blgSync_r;
  logic                supplyGood, blGood;
  logic [`WAIT_W-1:0]  waitMs_r;
  logic                msTick, pwmTick, stepClr;
  logic [`DUTY_W-1:0]  pwmCnt_r;
  logic                pwmRun_r;

  // Elapsed time in the current state has reached a limit
  function automatic logic reached(input logic [`WAIT_W-1:0] cnt,
                                   input logic [`WAIT_W-1:0] lim);
    return cnt >= lim;
  endfunction : reached

  // Steps in which the dimming output runs
  function automatic logic pwmActive(input seq_state_t s);
    return s inside {S_EN_WAIT, S_ON, S_EN_OFF};
  endfunction : pwmActive

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      supSync_r <= 2'h0;
      blgSync_r <= 2'h0;
    end else begin
      supSync_r <= {supSync_r[0], supplyGoodPin};
      blgSync_r <= {blgSync_r[0], blPowerGoodPin};
    end
  end
  assign supplyGood = supSync_r[1];
  assign blGood     = blgSync_r[1];

  // ----------------------------------------------------------------------
  // Millisecond and PWM dividers
  // ----------------------------------------------------------------------
  assign stepClr = (state_nxt != state_r);

  ms_tick_gen #(.DIV(MS_CYCLES)) msDiv (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clear (stepClr),
    .tick  (msTick)
  );

  ms_tick_gen #(.DIV(`PWM_TICK_CYCLES)) pwmDiv (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clear (1'b0),
    .tick  (pwmTick)
  );

  // Milliseconds spent in the current state, restarted on each step
  always_ff @(posedge mclk) begin
    if (!rst_n || stepClr) begin
      waitMs_r <= '0;
    end else if (msTick && waitMs_r != `WAIT_MAX) begin
      waitMs_r <= waitMs_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Sequence state machine
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:     if (powerReq) state_nxt = S_SUP_WAIT;
      S_SUP_WAIT: begin
        if (!powerReq) state_nxt = S_SUP_OFF;
        else if (supplyGood) state_nxt = S_SIG_WAIT;
        else if (reached(waitMs_r, `SUP_TIMEOUT_MS)) state_nxt = S_SUP_OFF;
      end
      S_SIG_WAIT: begin
        if (!powerReq || !supplyGood) state_nxt = S_SUP_OFF;
        else if (reached(waitMs_r, `T2_MIN_MS)) state_nxt = S_BLP_WAIT;
      end
      S_BLP_WAIT: begin
        if (!powerReq) state_nxt = S_SIG_HOLD;
        else if (reached(waitMs_r, `T3_MIN_MS)) state_nxt = S_BLG_WAIT;
      end
      S_BLG_WAIT: begin
        if (!powerReq) state_nxt = S_BLP_OFF;
        else if (blGood) state_nxt = S_PWM_WAIT;
        else if (reached(waitMs_r, `BLG_TIMEOUT_MS)) state_nxt = S_BLP_OFF;
      end
      S_PWM_WAIT: begin
        if (!powerReq || !blGood) state_nxt = S_BLP_OFF;
        else if (reached(waitMs_r, `T5_MIN_MS)) state_nxt = S_EN_WAIT;
      end
      S_EN_WAIT: begin
        if (!powerReq) state_nxt = S_PWM_OFF;
        else if (reached(waitMs_r, `T6_MIN_MS)) state_nxt = S_ON;
      end
      S_ON:       if (!powerReq) state_nxt = S_EN_OFF;
      S_EN_OFF:   begin
        if (reached(waitMs_r, `T7_MIN_MS)) state_nxt = S_PWM_OFF;
      end
      S_PWM_OFF:  if (reached(waitMs_r, `T8_MIN_MS)) state_nxt = S_BLP_OFF;
      S_BLP_OFF:  state_nxt = S_SIG_HOLD;
      S_SIG_HOLD: if (reached(waitMs_r, `T10_MIN_MS)) state_nxt = S_SUP_OFF;
      S_SUP_OFF:  state_nxt = S_OFF_WAIT;
      S_OFF_WAIT: if (reached(waitMs_r, OFF_MS)) state_nxt = S_IDLE;
      default:    state_nxt = S_IDLE;
    endcase
    // Lost supply drops every pin at once
    if (!supplyGood && state_r inside {S_BLP_WAIT, S_BLG_WAIT, S_PWM_WAIT, S_EN_WAIT,
                                       S_ON, S_EN_OFF, S_PWM_OFF, S_BLP_OFF, S_SIG_HOLD})
      state_nxt = S_SUP_OFF;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Dimming PWM generator
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pwmCnt_r <= '0;
    end else if (pwmTick) begin
      pwmCnt_r <= pwmCnt_r + 8'h01;
    end
  end

  // PWM runs from its start step until its stop step
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pwmRun_r <= 1'b0;
    end else begin
      pwmRun_r <= pwmActive(state_nxt);
    end
  end

  // ----------------------------------------------------------------------
  // Module pins, all registered and always driven
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      panelPins <= '0;
    end else begin
      panelPins.supplyEn    <= !(state_nxt inside {S_IDLE, S_SUP_OFF, S_OFF_WAIT});
      panelPins.signalValid <= state_nxt inside {S_BLP_WAIT, S_BLG_WAIT, S_PWM_WAIT,
                                                 S_EN_WAIT, S_ON, S_EN_OFF, S_PWM_OFF,
                                                 S_BLP_OFF, S_SIG_HOLD};
      panelPins.blPowerEn   <= state_nxt inside {S_BLG_WAIT, S_PWM_WAIT, S_EN_WAIT,
                                                 S_ON, S_EN_OFF, S_PWM_OFF};
      // Gated by the next step so it drops together with the supply
      panelPins.blDimming   <= pwmActive(state_nxt) && (pwmCnt_r < dimDuty);
      panelPins.blEnable    <= (state_nxt == S_ON);
    end
  end

  // ----------------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      panelOn <= 1'b0;
    end else begin
      panelOn <= (state_nxt == S_ON);
    end
  end

  // Sticky fault on timeout or supply loss, cleared by a new power-up
  always_ff @(posedge mclk) begin
    if (!rst_n || state_r == S_IDLE && powerReq) begin
      seqFault <= 1'b0;
    end else if (state_nxt == S_SUP_OFF && powerReq) begin
      seqFault <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_sig_after_supply;
    @(posedge mclk) disable iff (!rst_n)
      $rose(panelPins.signalValid) |-> $past(waitMs_r, 2) >= `T2_MIN_MS - 16'h0001
        && $past(waitMs_r, 2) <= `T2_MAX_MS && panelPins.supplyEn;
  endproperty
  a_sig_after_supply: assert property (p_sig_after_supply)
    else $error("signals valid outside supply window");

  property p_blp_after_sig;
    @(posedge mclk) disable iff (!rst_n)
      $rose(panelPins.blPowerEn) |-> $past(state_r) == S_BLP_WAIT
        && $past(waitMs_r) >= `T3_MIN_MS && panelPins.signalValid;
  endproperty
  a_blp_after_sig: assert property (p_blp_after_sig)
    else $error("backlight power before signal gap");

  property p_pwm_after_blg;
    @(posedge mclk) disable iff (!rst_n)
      $rose(pwmRun_r) |-> $past(state_r) == S_PWM_WAIT && $past(waitMs_r) >= `T5_MIN_MS;
  endproperty
  a_pwm_after_blg: assert property (p_pwm_after_blg)
    else $error("pwm started too early");

  property p_en_after_pwm;
    @(posedge mclk) disable iff (!rst_n)
      $rose(panelPins.blEnable) |-> pwmRun_r && $past(waitMs_r) >= `T6_MIN_MS;
  endproperty
  a_en_after_pwm: assert property (p_en_after_pwm)
    else $error("backlight enable too early");

  property p_en_before_pwm_off;
    @(posedge mclk) disable iff (!rst_n)
      $fell(pwmRun_r) |-> !panelPins.blEnable;
  endproperty
  a_en_before_pwm_off: assert property (p_en_before_pwm_off)
    else $error("pwm stopped while enable high");

  property p_blp_off_gap;
    @(posedge mclk) disable iff (!rst_n)
      $fell(panelPins.blPowerEn) && $past(state_r) == S_PWM_OFF
        |-> !pwmRun_r && $past(waitMs_r) >= `T8_MIN_MS;
  endproperty
  a_blp_off_gap: assert property (p_blp_off_gap)
    else $error("backlight power removed too soon");

  property p_sig_hold;
    @(posedge mclk) disable iff (!rst_n)
      $fell(panelPins.signalValid) |-> !panelPins.blPowerEn && !panelPins.blEnable;
  endproperty
  a_sig_hold: assert property (p_sig_hold)
    else $error("signals disabled with backlight on");

  property p_supply_after_sig;
    @(posedge mclk) disable iff (!rst_n)
      $fell(panelPins.signalValid) |-> ##[0:2] !panelPins.supplyEn;
  endproperty
  a_supply_after_sig: assert property (p_supply_after_sig)
    else $error("supply not removed after signals");

  property p_low_when_off;
    @(posedge mclk) disable iff (!rst_n)
      !panelPins.supplyEn |-> !panelPins.signalValid && !panelPins.blPowerEn
        && !panelPins.blEnable && !pwmRun_r && !panelPins.blDimming;
  endproperty
  a_low_when_off: assert property (p_low_when_off)
    else $error("pin high with supply off");

  property p_off_time;
    @(posedge mclk) disable iff (!rst_n)
      $past(state_r) == S_OFF_WAIT && state_r == S_IDLE |-> $past(waitMs_r) >= OFF_MS;
  endproperty
  a_off_time: assert property (p_off_time)
    else $error("off time cut short");

endmodule : panel_power_backlight_sequencer
